// file: rtl/reader_status_map.vh
// Purpose: Offsets, field positions, reset values and widths of the reader status register group.
// Assumes: Byte-wide registers on the serial register port, addresses as printed.
// Notes: Included by the register group only; the verification side uses literal addresses.
//
// Notes on behaviour
// - Soft framing error, data intact, sets error flag bit 5.
// - Hard framing error sets bit 4; CRC error bit 7; parity error bit 6.
// - Wake timer timeout sets bit 3 only when interrupt on every timeout chosen.
// - Amplitude differing from reference by more than delta sets bit 2.
// - Phase above reference by more than delta sets bit 1.
// - Capacitance above reference by more than delta sets bit 0.
// - Read-only status registers clear at power-up and on set-default command.
// - Reading the main interrupt register clears the whole error flag register.
// - Seven-bit count of unread FIFO bytes, 0 up to 96.
// - Underflow flag on reading beyond content; overflow flag on FIFO overflow.
// - Incomplete last byte sets its flag and three-bit valid bit count.
// - Valid bits of an incomplete last byte sit in the low positions.
// - Missing parity on last byte sets bit 0 of second FIFO status.
// - Empty FIFO reads count zero and clears incomplete flag and bit count.
// - Reading second FIFO status clears incomplete flag, bit count, missing parity.
// - Collision records full bytes before it in 7:4, bit offset in 3:1.
// - Collision in a message longer than anticollision leaves position unchanged.
// - Bit 0 set for parity bit collision, only on first collision.
// - Upper transmit count holds count bits 12 to 5; at most 8191 bytes.
// - Upper transmit count loads zero at power-up and on set-default.
// - Main interrupt summary bit 0 pends until error flag register is read.
// - Mask register at 0x16 suppresses requests of flags at same positions.
`ifndef READER_STATUS_MAP_VH
`define READER_STATUS_MAP_VH
`define ADDR_ERR_MASK 6'h16
`define ADDR_MAIN_IRQ 6'h17
`define ADDR_ERR_FLAGS 6'h19
`define ADDR_FIFO_FILL 6'h1A
`define ADDR_FIFO_TAIL 6'h1B
`define ADDR_COLLISION 6'h1C
`define ADDR_TX_COUNT_HIGH 6'h1D
`define ERR_CRC_BIT 7
`define ERR_PARITY_BIT 6
`define ERR_SOFT_FRAMING_BIT 5
`define ERR_HARD_FRAMING_BIT 4
`define ERR_WAKE_TIMER_BIT 3
`define ERR_WAKE_AMP_BIT 2
`define ERR_WAKE_PHASE_BIT 1
`define ERR_WAKE_CAP_BIT 0
`define TAIL_UNDERFLOW_BIT 6
`define TAIL_OVERFLOW_BIT 5
`define TAIL_INCOMPLETE_BIT 4
`define TAIL_BIT_COUNT_MSB 3
`define TAIL_BIT_COUNT_LSB 1
`define TAIL_MISSING_PARITY_BIT 0
`define COL_BYTE_MSB 7
`define COL_BYTE_LSB 4
`define COL_BIT_MSB 3
`define COL_BIT_LSB 1
`define COL_PARITY_BIT 0
`define MAIN_ERR_SUMMARY_BIT 0
`define FIFO_DEPTH_BYTES 96
`define REG_RESET_VALUE 8'h00
`endif

// file: rtl/partial_byte_packer.v
// Purpose: Moves the valid bits of a received byte into the low positions before FIFO write.
// Assumes: Bits are shifted in from the top, so n received bits occupy the upper n positions.
// Notes: A bit count of zero means the byte is complete and passes unchanged.
`timescale 1ns/100ps
module partial_byte_packer #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire byte_valid_i,
  input wire [WIDTH-1:0] byte_i,
  input wire [2:0] bit_count_i,
  output reg byte_valid_o,
  output reg [WIDTH-1:0] byte_o
);

  wire [3:0] shift_w;

  assign shift_w = (bit_count_i == 3'h0) ? 4'h0 : (4'h8 - {1'b0, bit_count_i});

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byte_valid_o <= 1'b0;
      byte_o <= {WIDTH{1'b0}};
    end else begin
      byte_valid_o <= byte_valid_i;
      if (byte_valid_i) begin
        byte_o <= byte_i >> shift_w;
      end
    end
  end

endmodule // partial_byte_packer

// file: rtl/reader_status_register_group.v
// Purpose: Error and wake-up flags, FIFO status, collision position and upper transmit count.
// Assumes: Register reads and writes arrive as one-cycle strobes from the serial host port.
// Notes: Read data is registered and appears one cycle after the read strobe.
`timescale 1ns/100ps
`include "reader_status_map.vh"
module reader_status_register_group #(
  parameter MEAS_WIDTH = 8,
  parameter COUNT_WIDTH = 7
) (
  input wire clk_i,
  input wire rst_b_i,
  // Register port.
  input wire [5:0] reg_addr_i,
  input wire reg_rd_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // Command decoder.
  input wire set_default_i,
  // CRC, parity and framing error events, one-cycle pulses.
  input wire crc_err_i,
  input wire parity_err_i,
  input wire soft_framing_err_i,
  input wire hard_framing_err_i,
  // Wake-up timer and measurements.
  input wire wake_timeout_i,
  input wire wake_irq_every_timeout_i,
  input wire amp_meas_valid_i,
  input wire [MEAS_WIDTH-1:0] amp_meas_i,
  input wire [MEAS_WIDTH-1:0] amp_ref_i,
  input wire [MEAS_WIDTH-1:0] amp_delta_i,
  input wire phase_meas_valid_i,
  input wire [MEAS_WIDTH-1:0] phase_meas_i,
  input wire [MEAS_WIDTH-1:0] phase_ref_i,
  input wire [MEAS_WIDTH-1:0] phase_delta_i,
  input wire cap_meas_valid_i,
  input wire [MEAS_WIDTH-1:0] cap_meas_i,
  input wire [MEAS_WIDTH-1:0] cap_ref_i,
  input wire [MEAS_WIDTH-1:0] cap_delta_i,
  // FIFO side.
  input wire [COUNT_WIDTH-1:0] fifo_count_i,
  input wire fifo_underflow_i,
  input wire fifo_overflow_i,
  input wire rx_last_byte_i,
  input wire [7:0] rx_byte_i,
  input wire [2:0] rx_last_bits_i,
  input wire rx_last_no_parity_i,
  // Collision reporting.
  input wire rx_start_i,
  input wire collision_i,
  input wire [3:0] collision_byte_i,
  input wire [2:0] collision_bit_i,
  input wire collision_in_parity_i,
  input wire collision_long_msg_i,
  // Outputs to the rest of the device.
  output reg err_summary_o,
  output reg err_irq_o,
  output reg [7:0] tx_count_high_o,
  output wire rx_fifo_wr_o,
  output wire [7:0] rx_fifo_byte_o
);

  reg [7:0] err_flags_q;
  reg [7:0] err_flags_d;
  reg [7:0] err_mask_q;
  reg [COUNT_WIDTH-1:0] fill_count_q;
  reg underflow_q;
  reg overflow_q;
  reg incomplete_q;
  reg [2:0] last_bits_q;
  reg missing_parity_q;
  reg [7:0] collision_q;
  reg first_col_seen_q;
  reg summary_d;
  reg [7:0] rdata_d;
  reg [7:0] err_events;

  wire rd_main;
  wire rd_err;
  wire rd_tail;
  wire fifo_empty;
  wire [7:0] err_pending;

  // Absolute difference of two measurement words.
  function [MEAS_WIDTH-1:0] abs_diff;
    input [MEAS_WIDTH-1:0] a;
    input [MEAS_WIDTH-1:0] b;
    begin
      abs_diff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // True when the measurement lies above the reference by more than delta.
  function above_by;
    input [MEAS_WIDTH-1:0] meas;
    input [MEAS_WIDTH-1:0] ref_val;
    input [MEAS_WIDTH-1:0] delta;
    begin
      above_by = (meas > ref_val) && ((meas - ref_val) > delta);
    end
  endfunction

  assign rd_main = reg_rd_i && (reg_addr_i == `ADDR_MAIN_IRQ);
  assign rd_err = reg_rd_i && (reg_addr_i == `ADDR_ERR_FLAGS);
  assign rd_tail = reg_rd_i && (reg_addr_i == `ADDR_FIFO_TAIL);
  assign fifo_empty = (fifo_count_i == {COUNT_WIDTH{1'b0}});
  assign err_pending = err_flags_d & ~err_mask_q;

  // Events that set the error and wake-up flags this cycle.
  always @* begin
    err_events = 8'h00;
    err_events[`ERR_CRC_BIT] = crc_err_i;
    err_events[`ERR_PARITY_BIT] = parity_err_i;
    err_events[`ERR_SOFT_FRAMING_BIT] = soft_framing_err_i;
    err_events[`ERR_HARD_FRAMING_BIT] = hard_framing_err_i;
    err_events[`ERR_WAKE_TIMER_BIT] = wake_timeout_i && wake_irq_every_timeout_i;
    err_events[`ERR_WAKE_AMP_BIT] = amp_meas_valid_i &&
      (abs_diff(amp_meas_i, amp_ref_i) > amp_delta_i);
    err_events[`ERR_WAKE_PHASE_BIT] = phase_meas_valid_i &&
      above_by(phase_meas_i, phase_ref_i, phase_delta_i);
    err_events[`ERR_WAKE_CAP_BIT] = cap_meas_valid_i &&
      above_by(cap_meas_i, cap_ref_i, cap_delta_i);
  end

  // Flags hold until the main interrupt read; a new event in that cycle survives.
  always @* begin
    err_flags_d = err_flags_q;
    if (rd_main) begin
      err_flags_d = 8'h00;
    end
    err_flags_d = err_flags_d | err_events;
  end

  // Summary is set by an unmasked event and pends until cleared by reading the flags.
  always @* begin
    summary_d = err_summary_o;
    if (rd_err) begin
      summary_d = 1'b0;
    end
    if (|(err_events & ~err_mask_q)) begin
      summary_d = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_flags_q <= `REG_RESET_VALUE;
      err_mask_q <= `REG_RESET_VALUE;
      err_summary_o <= 1'b0;
      err_irq_o <= 1'b0;
    end else if (set_default_i) begin
      err_flags_q <= `REG_RESET_VALUE;
      err_mask_q <= `REG_RESET_VALUE;
      err_summary_o <= 1'b0;
      err_irq_o <= 1'b0;
    end else begin
      err_flags_q <= err_flags_d;
      if (reg_wr_i && (reg_addr_i == `ADDR_ERR_MASK)) begin
        err_mask_q <= reg_wdata_i;
      end
      err_summary_o <= summary_d;
      err_irq_o <= |err_pending;
    end
  end

  // FIFO fill count and tail status.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fill_count_q <= {COUNT_WIDTH{1'b0}};
      underflow_q <= 1'b0;
      overflow_q <= 1'b0;
      incomplete_q <= 1'b0;
      last_bits_q <= 3'h0;
      missing_parity_q <= 1'b0;
    end else if (set_default_i) begin
      fill_count_q <= {COUNT_WIDTH{1'b0}};
      underflow_q <= 1'b0;
      overflow_q <= 1'b0;
      incomplete_q <= 1'b0;
      last_bits_q <= 3'h0;
      missing_parity_q <= 1'b0;
    end else begin
      fill_count_q <= fifo_count_i;
      if (fifo_underflow_i) begin
        underflow_q <= 1'b1;
      end
      if (fifo_overflow_i) begin
        overflow_q <= 1'b1;
      end
      if (rx_last_byte_i) begin
        incomplete_q <= (rx_last_bits_i != 3'h0);
        last_bits_q <= rx_last_bits_i;
        missing_parity_q <= rx_last_no_parity_i;
      end else if (rd_tail) begin
        incomplete_q <= 1'b0;
        last_bits_q <= 3'h0;
        missing_parity_q <= 1'b0;
      end else if (fifo_empty) begin
        incomplete_q <= 1'b0;
        last_bits_q <= 3'h0;
      end
    end
  end

  // Collision position, recorded once per frame for short anticollision messages.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      collision_q <= `REG_RESET_VALUE;
      first_col_seen_q <= 1'b0;
    end else if (set_default_i) begin
      collision_q <= `REG_RESET_VALUE;
      first_col_seen_q <= 1'b0;
    end else if (rx_start_i) begin
      first_col_seen_q <= 1'b0;
    end else if (collision_i && !collision_long_msg_i) begin
      first_col_seen_q <= 1'b1;
      if (!first_col_seen_q) begin
        collision_q[`COL_BYTE_MSB:`COL_BYTE_LSB] <= collision_byte_i;
        collision_q[`COL_BIT_MSB:`COL_BIT_LSB] <= collision_bit_i;
        collision_q[`COL_PARITY_BIT] <= collision_in_parity_i;
      end
    end
  end

  // Upper transmit count, bits 12 down to 5 of the byte count.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_count_high_o <= `REG_RESET_VALUE;
    end else if (set_default_i) begin
      tx_count_high_o <= `REG_RESET_VALUE;
    end else if (reg_wr_i && (reg_addr_i == `ADDR_TX_COUNT_HIGH)) begin
      tx_count_high_o <= reg_wdata_i;
    end
  end

  // Read data decode; unmapped addresses read zero.
  always @* begin
    rdata_d = 8'h00;
    if (reg_addr_i == `ADDR_ERR_MASK) begin
      rdata_d = err_mask_q;
    end else if (reg_addr_i == `ADDR_ERR_FLAGS) begin
      rdata_d = err_flags_q;
    end else if (reg_addr_i == `ADDR_FIFO_FILL) begin
      rdata_d = {1'b0, fill_count_q};
      if (fill_count_q == {COUNT_WIDTH{1'b0}}) begin
        rdata_d = 8'h00;
      end
    end else if (reg_addr_i == `ADDR_FIFO_TAIL) begin
      rdata_d[`TAIL_UNDERFLOW_BIT] = underflow_q;
      rdata_d[`TAIL_OVERFLOW_BIT] = overflow_q;
      rdata_d[`TAIL_INCOMPLETE_BIT] = incomplete_q;
      rdata_d[`TAIL_BIT_COUNT_MSB:`TAIL_BIT_COUNT_LSB] = last_bits_q;
      rdata_d[`TAIL_MISSING_PARITY_BIT] = missing_parity_q;
    end else if (reg_addr_i == `ADDR_COLLISION) begin
      rdata_d = collision_q;
    end else if (reg_addr_i == `ADDR_TX_COUNT_HIGH) begin
      rdata_d = tx_count_high_o;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end
  end

  partial_byte_packer #(
    .WIDTH(8)
  ) u_packer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .byte_valid_i(rx_last_byte_i),
    .byte_i(rx_byte_i),
    .bit_count_i(rx_last_bits_i),
    .byte_valid_o(rx_fifo_wr_o),
    .byte_o(rx_fifo_byte_o)
  );

endmodule // reader_status_register_group

// file: verif/reader_status_chk.sv
// Purpose: Port-level checks of the reader status register group.
// Assumes: Only the top module's ports are visible; one clock domain.
// Notes: Attached by the bind at the foot of this file.
`timescale 1ns/100ps
module reader_status_chk #(
  parameter COUNT_WIDTH = 7
) (
  input logic clk_i,
  input logic rst_b_i,
  input logic [5:0] reg_addr_i,
  input logic reg_rd_i,
  input logic reg_wr_i,
  input logic [7:0] reg_wdata_i,
  input logic [7:0] reg_rdata_o,
  input logic set_default_i,
  input logic crc_err_i,
  input logic [COUNT_WIDTH-1:0] fifo_count_i,
  input logic rx_last_byte_i,
  input logic [7:0] rx_byte_i,
  input logic [2:0] rx_last_bits_i,
  input logic err_summary_o,
  input logic [7:0] tx_count_high_o,
  input logic rx_fifo_wr_o,
  input logic [7:0] rx_fifo_byte_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence err_rd;
    reg_rd_i && reg_addr_i == 6'h19 && !set_default_i;
  endsequence
  sequence tail_rd;
    reg_rd_i && reg_addr_i == 6'h1B && !rx_last_byte_i && !set_default_i;
  endsequence
  tx_write_a: assert property (
    reg_wr_i && reg_addr_i == 6'h1D && !set_default_i |=> tx_count_high_o == $past(reg_wdata_i))
    else $error("upper transmit count not written");
  tx_default_a: assert property (
    set_default_i |=> tx_count_high_o == 8'h00) else $error("upper transmit count kept");
  crc_flag_a: assert property (
    crc_err_i && !set_default_i ##1 !set_default_i && !(reg_rd_i && reg_addr_i == 6'h17)
    ##1 err_rd |=> reg_rdata_o[7]) else $error("crc flag missing");
  sum_hold_a: assert property (
    $fell(err_summary_o) |-> $past(reg_rd_i && reg_addr_i == 6'h19 || set_default_i))
    else $error("summary dropped without read");
  fill_read_a: assert property (
    reg_rd_i && reg_addr_i == 6'h1A && !set_default_i && $stable(fifo_count_i) && $past(rst_b_i)
    && !$past(set_default_i) |=> reg_rdata_o == {1'b0, $past(fifo_count_i)})
    else $error("fill count wrong");
  pack_byte_a: assert property (
    rx_last_byte_i |=> rx_fifo_wr_o && rx_fifo_byte_o == ($past(rx_last_bits_i) == 3'h0 ?
    $past(rx_byte_i) : $past(rx_byte_i) >> (4'h8 - $past(rx_last_bits_i))))
    else $error("packed byte wrong");
  no_write_a: assert property (!rx_last_byte_i |=> !rx_fifo_wr_o)
    else $error("spurious fifo write");
  tail_clear_a: assert property (
    tail_rd ##1 !rx_last_byte_i ##1 tail_rd |=> reg_rdata_o[4:0] == 5'h00)
    else $error("tail bits not cleared by read");
  top_zero_a: assert property (
    reg_rd_i && (reg_addr_i == 6'h1A || reg_addr_i == 6'h1B) |=> !reg_rdata_o[7])
    else $error("unused bit set");
endmodule // reader_status_chk
bind reader_status_register_group reader_status_chk #(.COUNT_WIDTH(COUNT_WIDTH)) i_chk (.*);

// file: verif/host_model.sv
// Purpose: Host side of the serial register port, issuing byte reads and writes.
// Assumes: Each task is entered in the time step of a rising clock edge.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/100ps
module host_model (
  input wire clk_i,
  input wire [7:0] reg_rdata_o,
  output reg [5:0] reg_addr_i,
  output reg reg_rd_i,
  output reg reg_wr_i,
  output reg [7:0] reg_wdata_i
);
  initial begin
    {reg_addr_i, reg_rd_i, reg_wr_i, reg_wdata_i} = 16'h0000;
  end
  task rd(input [5:0] a, output [7:0] d);
    begin
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      reg_addr_i <= ~a;
      @(posedge clk_i);
      d = reg_rdata_o;
    end
  endtask
  task wr(input [5:0] a, input [7:0] v);
    begin
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      reg_addr_i <= ~a;
      reg_wdata_i <= ~v;
      @(posedge clk_i);
    end
  endtask
endmodule // host_model

// file: verif/reader_status_register_group_tb.sv
// Purpose: Self-checking bench of the reader status register group.
// Assumes: Registers are reached through the host model tasks.
// Notes: Event inputs are pulsed for one cycle by the tk task.
`timescale 1ns/100ps
module reader_status_register_group_tb;
  reg clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg set_default_i, crc_err_i, parity_err_i, soft_framing_err_i, hard_framing_err_i;
  reg wake_timeout_i, wake_irq_every_timeout_i, amp_meas_valid_i, phase_meas_valid_i;
  reg cap_meas_valid_i, fifo_underflow_i, fifo_overflow_i, rx_last_byte_i, rx_last_no_parity_i;
  reg rx_start_i, collision_i, collision_in_parity_i, collision_long_msg_i;
  reg [7:0] amp_meas_i, amp_ref_i, amp_delta_i, phase_meas_i, phase_ref_i, phase_delta_i;
  reg [7:0] cap_meas_i, cap_ref_i, cap_delta_i, rx_byte_i;
  reg [6:0] fifo_count_i;
  reg [3:0] collision_byte_i;
  reg [2:0] rx_last_bits_i, collision_bit_i;
  wire [5:0] reg_addr_i;
  wire reg_rd_i, reg_wr_i, err_summary_o, err_irq_o, rx_fifo_wr_o;
  wire [7:0] reg_wdata_i, reg_rdata_o, tx_count_high_o, rx_fifo_byte_o;
  integer fail_count = 0;
  integer checks_done = 0;
  integer i;
  reg [7:0] d;
  always #10 clk_i = ~clk_i;
  reader_status_register_group i_dut (.*);
  host_model i_host (.*);
  task zp;
    begin
      {set_default_i, crc_err_i, parity_err_i, soft_framing_err_i, hard_framing_err_i} <= 5'h00;
      {wake_timeout_i, amp_meas_valid_i, phase_meas_valid_i, cap_meas_valid_i} <= 4'h0;
      {fifo_underflow_i, fifo_overflow_i, rx_last_byte_i, rx_start_i, collision_i} <= 5'h00;
    end
  endtask
  task tk;
    begin
      @(posedge clk_i);
      zp;
      @(posedge clk_i);
    end
  endtask
  task cmp(input [7:0] g, input [7:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
        fail_count = fail_count + 1;
      end
    end
  endtask
  task rc(input [5:0] a, input [7:0] e);
    begin
      i_host.rd(a, d);
      cmp(d, e);
    end
  endtask
  task test_done;
    begin
      if (fail_count == 0 && checks_done > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  task t_tx;
    begin
      i_host.wr(6'h1D, 8'hA5);
      rc(6'h1D, 8'hA5);
      cmp(tx_count_high_o, 8'hA5);
      i_host.wr(6'h19, 8'hFF);
      rc(6'h19, 8'h00);
      set_default_i <= 1'b1;
      tk;
      rc(6'h1D, 8'h00);
    end
  endtask
  task t_err;
    begin
      wake_timeout_i <= 1'b1;
      tk;
      rc(6'h19, 8'h00);
      i_host.wr(6'h16, 8'h80);
      crc_err_i <= 1'b1;
      tk;
      rc(6'h19, 8'h80);
      cmp({7'h00, err_irq_o}, 8'h00);
      wake_irq_every_timeout_i <= 1'b1;
      {parity_err_i, soft_framing_err_i, hard_framing_err_i, wake_timeout_i} <= 4'hF;
      tk;
      tk;
      cmp({6'h00, err_irq_o, err_summary_o}, 8'h03);
      rc(6'h19, 8'hF8);
      cmp({7'h00, err_summary_o}, 8'h00);
      rc(6'h19, 8'hF8);
      rc(6'h17, 8'h00);
      rc(6'h19, 8'h00);
      i_host.wr(6'h16, 8'h00);
    end
  endtask
  task t_wake;
    begin
      amp_meas_i <= 8'h6F;
      phase_meas_i <= 8'h90;
      cap_meas_i <= 8'h91;
      {amp_meas_valid_i, phase_meas_valid_i, cap_meas_valid_i} <= 3'h7;
      tk;
      rc(6'h19, 8'h05);
      rc(6'h17, 8'h00);
      amp_meas_i <= 8'h90;
      phase_meas_i <= 8'h91;
      cap_meas_i <= 8'h6F;
      {amp_meas_valid_i, phase_meas_valid_i, cap_meas_valid_i} <= 3'h7;
      tk;
      rc(6'h19, 8'h02);
    end
  endtask
  task t_fifo;
    begin
      fifo_count_i <= 7'h60;
      {fifo_underflow_i, fifo_overflow_i} <= 2'h3;
      tk;
      rc(6'h1A, 8'h60);
      rc(6'h1B, 8'h60);
      rx_byte_i <= 8'hE0;
      rx_last_bits_i <= 3'h3;
      rx_last_no_parity_i <= 1'b1;
      rx_last_byte_i <= 1'b1;
      tk;
      cmp(rx_fifo_byte_o, 8'h07);
      rc(6'h1B, 8'h77);
      rc(6'h1B, 8'h60);
      rx_last_byte_i <= 1'b1;
      tk;
      fifo_count_i <= 7'h00;
      tk;
      rc(6'h1B, 8'h61);
      rc(6'h1A, 8'h00);
    end
  endtask
  task t_col;
    begin
      rx_start_i <= 1'b1;
      tk;
      {collision_byte_i, collision_bit_i, collision_in_parity_i} <= 8'h57;
      collision_i <= 1'b1;
      tk;
      rc(6'h1C, 8'h57);
      collision_byte_i <= 4'h2;
      collision_i <= 1'b1;
      tk;
      rc(6'h1C, 8'h57);
      rx_start_i <= 1'b1;
      collision_long_msg_i <= 1'b1;
      tk;
      collision_i <= 1'b1;
      tk;
      rc(6'h1C, 8'h57);
      collision_long_msg_i <= 1'b0;
      collision_in_parity_i <= 1'b0;
      collision_i <= 1'b1;
      tk;
      rc(6'h1C, 8'h26);
      set_default_i <= 1'b1;
      tk;
      rc(6'h1C, 8'h00);
      rc(6'h1B, 8'h00);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count = fail_count + 1;
    test_done;
  end
  initial begin
    {amp_ref_i, phase_ref_i, cap_ref_i} = {3{8'h80}};
    {amp_delta_i, phase_delta_i, cap_delta_i} = {3{8'h10}};
    {amp_meas_i, phase_meas_i, cap_meas_i, rx_byte_i, fifo_count_i, collision_byte_i} = 43'h0;
    {rx_last_bits_i, collision_bit_i, rx_last_no_parity_i, collision_in_parity_i} = 8'h00;
    {collision_long_msg_i, wake_irq_every_timeout_i} = 2'h0;
    zp;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (i = 6'h16; i < 6'h1E; i = i + 1) rc(i[5:0], 8'h00);
    rc(6'h3F, 8'h00);
    t_tx;
    t_err;
    t_wake;
    t_fifo;
    t_col;
    test_done;
  end
endmodule // reader_status_register_group_tb
